// ==== global_config_pkg.sv ====
package global_config_pkg;

  // register indices seen through the data port
  localparam logic [7:0] IDX_SOFT_RESET = 8'h02;
  localparam logic [7:0] IDX_UNIT_NUMBER = 8'h07;
  localparam logic [7:0] IDX_RSVD_FIRST = 8'h20;
  localparam logic [7:0] IDX_RSVD_LAST = 8'h24;
  localparam logic [7:0] IDX_SERIAL_SHARE = 8'h26;
  localparam logic [7:0] IDX_PORT_SELECT = 8'h27;
  localparam logic [7:0] IDX_UNIT_FIRST = 8'h30;

  // field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int CLK_RATE_BIT = 7;
  localparam int TX_DELAY_BIT = 2;
  localparam int IRQ_MODE_BIT = 1;
  localparam int IRQ_MERGE_BIT = 0;
  localparam int ALT_PORT_BIT = 4;
  localparam int BIT_SELECT_STATUS_BIT = 1;
  localparam int SEQ_STATUS_BIT = 0;

  // reset values
  localparam logic [7:0] UNIT_NUMBER_RESET = 8'h00;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic CLK_RATE_RESET = 1'h0;
  localparam logic TX_DELAY_RESET = 1'h0;
  localparam logic IRQ_MODE_RESET = 1'h0;
  localparam logic IRQ_MERGE_RESET = 1'h0;
  localparam logic ALT_PORT_RESET = 1'h0;

  // configuration index ports, data port is the next address
  localparam logic [15:0] CFG_PORT_STD = 16'h002E;
  localparam logic [15:0] CFG_PORT_ALT = 16'h004E;

  // logical unit numbers
  localparam logic [7:0] UNIT_FLOPPY = 8'h00;
  localparam logic [7:0] UNIT_SERIAL1 = 8'h01;
  localparam logic [7:0] UNIT_SERIAL2 = 8'h02;
  localparam logic [7:0] UNIT_PARALLEL = 8'h03;
  localparam logic [7:0] UNIT_MONITOR = 8'h04;
  localparam logic [7:0] UNIT_KEYBOARD = 8'h05;
  localparam logic [7:0] UNIT_GENERAL_IO = 8'h06;
  localparam logic [7:0] UNIT_BIT_SELECT = 8'h07;
  localparam logic [7:0] UNIT_POWER_EVENT = 8'h0A;
  localparam int UNIT_COUNT = 11;

  // timing counts
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;
  localparam logic [3:0] IRQ_PULSE_CYCLES = 4'h4;

  typedef enum logic [1:0] {IRQ_IDLE = 2'h1, IRQ_PULSE = 2'h2} irq_state_t;

endpackage

// ==== serial_ctl_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface serial_ctl_if;
  logic soft_clr;
  logic tx_delay;
  logic merge;
  logic pulse_mode;
  logic [1:0] hold_write;
  logic [1:0] bit_tick;
  logic [1:0] tx_start;
  logic [1:0] irq_req;
  logic irq1;
  logic irq2;
  logic shared_irq_n;
  logic shared_irq_oe;
  modport ctrl (output soft_clr, tx_delay, merge, pulse_mode, hold_write, bit_tick, irq_req,
                input tx_start, irq1, irq2, shared_irq_n, shared_irq_oe);
  modport tx (input soft_clr, tx_delay, hold_write, bit_tick, output tx_start);
  modport irq (input soft_clr, merge, pulse_mode, irq_req,
               output irq1, irq2, shared_irq_n, shared_irq_oe);
endinterface
`default_nettype wire

// ==== serial_tx_start.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_tx_start
  import global_config_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // control carrier
  serial_ctl_if.tx sc
);

  typedef struct packed
  {
    logic pending;
    logic start;
  } tx_state_t;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      tx_state_t st;
      tx_state_t next_st;
      always_comb
      begin
        next_st = st;
        next_st.start = 1'b0;
        if (sc.soft_clr)
        begin
          next_st.pending = 1'b0;
        end
        else if (sc.hold_write[ch] && !sc.tx_delay)
        begin
          next_st.start = 1'b1;
          next_st.pending = 1'b0;
        end
        else if (sc.hold_write[ch])
        begin
          next_st.pending = 1'b1;
        end
        else if (st.pending && sc.bit_tick[ch])
        begin
          // the bit timer restarts on the write, so its next tick is one bit time later
          next_st.start = 1'b1;
          next_st.pending = 1'b0;
        end
      end
      always_ff @(posedge sys_clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          st <= '0;
        end
        else if (ce_i)
        begin
          st <= next_st;
        end
      end
      assign sc.tx_start[ch] = st.start;
    end
  endgenerate

endmodule
`default_nettype wire

// ==== serial_irq_route.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_irq_route
  import global_config_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // control carrier
  serial_ctl_if.irq sc
);

  typedef struct packed
  {
    irq_state_t fsm;
    logic [3:0] cnt;
    logic prev_any;
    logic irq1;
    logic irq2;
    logic drive;
  } irq_route_t;

  irq_route_t st;
  irq_route_t next_st;
  logic any_req;

  assign any_req = |sc.irq_req;

  always_comb
  begin
    next_st = st;
    next_st.prev_any = any_req;
    if (sc.soft_clr || !sc.merge)
    begin
      next_st.fsm = IRQ_IDLE;
      next_st.cnt = 4'h0;
      next_st.drive = 1'b0;
      next_st.irq1 = sc.irq_req[0] && !sc.soft_clr;
      next_st.irq2 = sc.irq_req[1] && !sc.soft_clr;
    end
    else
    begin
      next_st.irq1 = 1'b0;
      next_st.irq2 = 1'b0;
      if (!sc.pulse_mode)
      begin
        next_st.fsm = IRQ_IDLE;
        next_st.drive = any_req;
      end
      else
      begin
        case (st.fsm)
          IRQ_IDLE:
          begin
            next_st.drive = 1'b0;
            if (any_req && !st.prev_any)
            begin
              next_st.fsm = IRQ_PULSE;
              next_st.cnt = 4'h1;
              next_st.drive = 1'b1;
            end
          end
          IRQ_PULSE:
          begin
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == IRQ_PULSE_CYCLES)
            begin
              next_st.fsm = IRQ_IDLE;
              next_st.drive = 1'b0;
            end
          end
          default:
          begin
            next_st.fsm = IRQ_IDLE;
            next_st.drive = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st <= '{fsm: IRQ_IDLE, default: '0};
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  // shared line is open drain: only ever pulled low
  assign sc.irq1 = st.irq1;
  assign sc.irq2 = st.irq2;
  assign sc.shared_irq_n = !st.drive;
  assign sc.shared_irq_oe = st.drive;

endmodule
`default_nettype wire

// ==== global_config_registers.sv ====
// Overview of operation
// - Writing one to bit 0 of index 02h resets all main-supply registers and logic.
// - Logical device number selects which unit's configuration bank is visible.
// - Logical device number reads 00h after reset, selecting the floppy bank.
// - Bit 7 of index 26h: 0 means 48MHz reference, 1 means 24MHz; dividers follow.
// - Bit 2: 0 transmits at holding-register write, 1 starts one bit time later.
// - Bit 1: shared interrupt is level-low when 0, low pulse when 1.
// - Bit 0 set merges both serial interrupts onto one request line.
// - Bit 4 of index 27h picks index/data ports 2E/2F (0) or 4E/4F (1).
// - Port pair bit is captured at power-on from the serial-out strap pin.
// - Read-only bit 1 shows bit-select strap: 1 enables bit select, disables group six.
// - Read-only bit 0 shows sequencing strap: 1 enables power sequence control.
`timescale 1ns/1ps
`default_nettype none
module global_config_registers
  import global_config_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // host i/o cycles, one-cycle strobes on sys_clk_i
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rdata_valid_o,
  // per-unit configuration banks
  output logic [UNIT_COUNT-1:0] unit_select_o,
  output logic [7:0] unit_index_o,
  output logic [7:0] unit_wdata_o,
  output logic unit_wr_o,
  output logic unit_rd_o,
  input wire logic [7:0] unit_rdata_i,
  // main supply reset and reference clock
  output logic main_supply_reset_o,
  input wire logic reference_clock_input_i,
  output logic input_clock_rate_select_o,
  output logic ref_tick_o,
  // serial ports
  input wire logic [1:0] transmit_holding_register_write_i,
  input wire logic [1:0] bit_tick_i,
  output logic [1:0] tx_start_o,
  input wire logic [1:0] serial_irq_req_i,
  output logic serial_irq1_o,
  output logic serial_irq2_o,
  output logic shared_irq_o,
  output logic shared_irq_oe_o,
  // straps and status
  input wire logic serial_out_strap_pin_i,
  input wire logic bit_select_strap_pin_i,
  input wire logic sequencing_strap_pin_i,
  output logic alternate_config_port_o,
  output logic bit_select_function_status_o,
  output logic general_io_group_six_enable_o,
  output logic sequencing_status_o
);

  typedef struct packed
  {
    logic [7:0] cfg_index;
    logic [7:0] unit_num;
    logic clk_rate;
    logic tx_delay;
    logic irq_mode;
    logic irq_merge;
    logic alt_port;
    logic strap_taken;
    logic [1:0] strap_cnt;
    logic [1:0] sync_sout;
    logic [1:0] sync_bit_sel;
    logic [1:0] sync_seq;
    logic [2:0] sync_ref;
    logic ref_phase;
    logic ref_tick;
    logic main_rst;
    logic [7:0] rdata;
    logic rvalid;
    logic unit_pend_rd;
    logic [7:0] uwdata;
    logic uwr;
    logic urd;
  } main_state_t;

  main_state_t st;
  main_state_t next_st;
  logic [15:0] index_port;
  logic [15:0] data_port;
  logic index_wr;
  logic data_wr;
  logic data_rd;
  logic unit_space;
  logic [7:0] global_rd;

  serial_ctl_if sc ();

  serial_tx_start u_tx
  (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .sc(sc.tx)
  );

  serial_irq_route u_irq
  (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .sc(sc.irq)
  );

  // port pair decode
  always_comb
  begin
    index_port = st.alt_port ? CFG_PORT_ALT : CFG_PORT_STD;
    data_port = index_port + 16'h0001;
    index_wr = io_wr_i && (io_addr_i == index_port);
    data_wr = io_wr_i && (io_addr_i == data_port);
    data_rd = io_rd_i && (io_addr_i == data_port);
    unit_space = st.cfg_index >= IDX_UNIT_FIRST;
  end

  // global register readback; unlisted and reserved indices read zero
  always_comb
  begin
    global_rd = 8'h00;
    case (st.cfg_index)
      IDX_UNIT_NUMBER:
      begin
        global_rd = st.unit_num;
      end
      IDX_SERIAL_SHARE:
      begin
        global_rd[CLK_RATE_BIT] = st.clk_rate;
        global_rd[TX_DELAY_BIT] = st.tx_delay;
        global_rd[IRQ_MODE_BIT] = st.irq_mode;
        global_rd[IRQ_MERGE_BIT] = st.irq_merge;
      end
      IDX_PORT_SELECT:
      begin
        global_rd[ALT_PORT_BIT] = st.alt_port;
        global_rd[BIT_SELECT_STATUS_BIT] = st.sync_bit_sel[1];
        global_rd[SEQ_STATUS_BIT] = st.sync_seq[1];
      end
      default:
      begin
        global_rd = 8'h00;
      end
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_st.main_rst = 1'b0;
    next_st.rvalid = 1'b0;
    next_st.uwr = 1'b0;
    next_st.urd = 1'b0;
    next_st.unit_pend_rd = 1'b0;
    // synchronisers: stage 0 is read only by stage 1
    next_st.sync_sout = {st.sync_sout[0], serial_out_strap_pin_i};
    next_st.sync_bit_sel = {st.sync_bit_sel[0], bit_select_strap_pin_i};
    next_st.sync_seq = {st.sync_seq[0], sequencing_strap_pin_i};
    next_st.sync_ref = {st.sync_ref[1:0], reference_clock_input_i};
    // power-on strap capture once the synchroniser has filled
    if (!st.strap_taken)
    begin
      if (st.strap_cnt == STRAP_SETTLE_CYCLES)
      begin
        next_st.alt_port = st.sync_sout[1];
        next_st.strap_taken = 1'b1;
      end
      else
      begin
        next_st.strap_cnt = st.strap_cnt + 2'h1;
      end
    end
    // 48MHz input is halved so downstream dividers always see a 24MHz rate
    next_st.ref_tick = 1'b0;
    if (st.sync_ref[1] && !st.sync_ref[2])
    begin
      next_st.ref_phase = !st.ref_phase;
      next_st.ref_tick = st.clk_rate || st.ref_phase;
    end
    // host access
    if (index_wr)
    begin
      next_st.cfg_index = io_wdata_i;
    end
    if (data_wr && unit_space)
    begin
      next_st.uwr = 1'b1;
      next_st.uwdata = io_wdata_i;
    end
    else if (data_wr)
    begin
      case (st.cfg_index)
        IDX_SOFT_RESET:
        begin
          next_st.main_rst = io_wdata_i[SOFT_RESET_BIT];
        end
        IDX_UNIT_NUMBER:
        begin
          next_st.unit_num = io_wdata_i;
        end
        IDX_SERIAL_SHARE:
        begin
          next_st.clk_rate = io_wdata_i[CLK_RATE_BIT];
          next_st.tx_delay = io_wdata_i[TX_DELAY_BIT];
          next_st.irq_mode = io_wdata_i[IRQ_MODE_BIT];
          next_st.irq_merge = io_wdata_i[IRQ_MERGE_BIT];
        end
        IDX_PORT_SELECT:
        begin
          // strap status bits are pin views, so only the port pair bit takes the write
          next_st.alt_port = io_wdata_i[ALT_PORT_BIT];
        end
        default:
        begin
          next_st.main_rst = 1'b0;
        end
      endcase
    end
    if (data_rd && unit_space)
    begin
      next_st.urd = 1'b1;
      next_st.unit_pend_rd = 1'b1;
    end
    else if (data_rd)
    begin
      next_st.rdata = global_rd;
      next_st.rvalid = 1'b1;
    end
    if (st.unit_pend_rd)
    begin
      next_st.rdata = unit_rdata_i;
      next_st.rvalid = 1'b1;
    end
    // main-supply registers return to defaults; port pair and straps live on standby
    if (st.main_rst)
    begin
      next_st.cfg_index = INDEX_RESET;
      next_st.unit_num = UNIT_NUMBER_RESET;
      next_st.clk_rate = CLK_RATE_RESET;
      next_st.tx_delay = TX_DELAY_RESET;
      next_st.irq_mode = IRQ_MODE_RESET;
      next_st.irq_merge = IRQ_MERGE_RESET;
      next_st.uwr = 1'b0;
      next_st.urd = 1'b0;
      next_st.unit_pend_rd = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st <= '{cfg_index: INDEX_RESET, unit_num: UNIT_NUMBER_RESET, clk_rate: CLK_RATE_RESET,
              tx_delay: TX_DELAY_RESET, irq_mode: IRQ_MODE_RESET, irq_merge: IRQ_MERGE_RESET,
              alt_port: ALT_PORT_RESET, default: '0};
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  // unit bank selection, one-hot; unlisted numbers select nothing
  genvar u;
  generate
    for (u = 0; u < UNIT_COUNT; u++)
    begin : g_unit
      localparam logic [7:0] UNIT_CODE = 8'(u);
      assign unit_select_o[u] = (st.unit_num == UNIT_CODE) && (UNIT_CODE != 8'h08) && (UNIT_CODE != 8'h09);
    end
  endgenerate

  assign sc.soft_clr = st.main_rst;
  assign sc.tx_delay = st.tx_delay;
  assign sc.merge = st.irq_merge;
  assign sc.pulse_mode = st.irq_mode;
  assign sc.hold_write = transmit_holding_register_write_i;
  assign sc.bit_tick = bit_tick_i;
  assign sc.irq_req = serial_irq_req_i;

  assign io_rdata_o = st.rdata;
  assign io_rdata_valid_o = st.rvalid;
  assign unit_index_o = st.cfg_index;
  assign unit_wdata_o = st.uwdata;
  assign unit_wr_o = st.uwr;
  assign unit_rd_o = st.urd;
  assign main_supply_reset_o = st.main_rst;
  assign input_clock_rate_select_o = st.clk_rate;
  assign ref_tick_o = st.ref_tick;
  assign tx_start_o = sc.tx_start;
  assign serial_irq1_o = sc.irq1;
  assign serial_irq2_o = sc.irq2;
  assign shared_irq_o = sc.shared_irq_n;
  assign shared_irq_oe_o = sc.shared_irq_oe;
  assign alternate_config_port_o = st.alt_port;
  assign bit_select_function_status_o = st.sync_bit_sel[1];
  assign general_io_group_six_enable_o = !st.sync_bit_sel[1];
  assign sequencing_status_o = st.sync_seq[1];

endmodule
`default_nettype wire

// ==== global_config_registers_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module global_config_registers_monitor
  import global_config_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // host side
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic io_rdata_valid_o,
  // unit banks
  input wire logic [UNIT_COUNT-1:0] unit_select_o,
  input wire logic unit_wr_o,
  input wire logic unit_rd_o,
  input wire logic [7:0] unit_rdata_i,
  input wire logic main_supply_reset_o,
  // serial ports
  input wire logic [1:0] transmit_holding_register_write_i,
  input wire logic [1:0] bit_tick_i,
  input wire logic [1:0] tx_start_o,
  input wire logic [1:0] serial_irq_req_i,
  input wire logic serial_irq1_o,
  input wire logic shared_irq_o,
  input wire logic shared_irq_oe_o,
  // straps
  input wire logic bit_select_function_status_o,
  input wire logic general_io_group_six_enable_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  chk_unit_onehot: assert property ($onehot0(unit_select_o) && unit_select_o[9:8] == 2'h0)
    else $error("unit select not one-hot");
  chk_soft_reset_ldn: assert property (main_supply_reset_o |=> !main_supply_reset_o && unit_select_o == 11'h001)
    else $error("soft reset did not restore unit select");
  chk_soft_reset_cause: assert property ($rose(main_supply_reset_o) |-> $past(io_wr_i))
    else $error("soft reset without host write");
  chk_group_six: assert property (general_io_group_six_enable_o == !bit_select_function_status_o)
    else $error("group six enable not inverse of status");
  chk_tx_cause: assert property (tx_start_o[0] |-> $past(transmit_holding_register_write_i[0]) || $past(bit_tick_i[0]))
    else $error("transmit start without cause");
  chk_irq_split: assert property (serial_irq1_o |-> $past(serial_irq_req_i[0]) && !shared_irq_oe_o)
    else $error("separate request without cause");
  chk_shared_low: assert property (shared_irq_oe_o |-> !shared_irq_o)
    else $error("shared line driven high");
  chk_read_source: assert property (io_rdata_valid_o |-> $past(io_rd_i) || $past(io_rd_i, 2))
    else $error("read data without read strobe");
  chk_unit_read: assert property (unit_rd_o |=> io_rdata_valid_o && io_rdata_o == $past(unit_rdata_i))
    else $error("unit read data not returned");
  chk_unit_write: assert property (unit_wr_o |-> $past(io_wr_i))
    else $error("unit write without host write");
endmodule
bind global_config_registers global_config_registers_monitor i_global_config_registers_monitor (.sys_clk_i, .nrst_i,
  .io_wr_i, .io_rd_i, .io_rdata_o, .io_rdata_valid_o, .unit_select_o, .unit_wr_o, .unit_rd_o, .unit_rdata_i,
  .main_supply_reset_o, .transmit_holding_register_write_i, .bit_tick_i, .tx_start_o, .serial_irq_req_i,
  .serial_irq1_o, .shared_irq_o, .shared_irq_oe_o, .bit_select_function_status_o, .general_io_group_six_enable_o);
`default_nettype wire

// ==== tb_global_config_registers.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_global_config_registers;
  import global_config_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  logic [15:0] io_addr_i = 16'h0000;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic [7:0] unit_rdata_i = 8'h00;
  logic reference_clock_input_i = 1'b0;
  logic [1:0] transmit_holding_register_write_i = 2'h0;
  logic [1:0] bit_tick_i = 2'h0;
  logic [1:0] serial_irq_req_i = 2'h0;
  logic serial_out_strap_pin_i = 1'b0;
  logic bit_select_strap_pin_i = 1'b0;
  logic sequencing_strap_pin_i = 1'b0;
  logic [7:0] io_rdata_o, unit_index_o, unit_wdata_o;
  logic [UNIT_COUNT-1:0] unit_select_o;
  logic [1:0] tx_start_o;
  logic io_rdata_valid_o, unit_wr_o, unit_rd_o, main_supply_reset_o, input_clock_rate_select_o, ref_tick_o;
  logic serial_irq1_o, serial_irq2_o, shared_irq_o, shared_irq_oe_o, alternate_config_port_o;
  logic bit_select_function_status_o, general_io_group_six_enable_o, sequencing_status_o;
  logic [31:0] seed = 32'h1DF43C76;
  logic [31:0] rs = 32'h1DF43C76;
  logic [15:0] base = CFG_PORT_STD;
  logic [7:0] v;
  logic [7:0] rq[$];
  logic [7:0] wq[$];
  int bad_count = 0;
  int num_checks = 0;
  int n;
  int ticks = 0;
  int t0;
  logic ref_hold = 1'b0;
  logic ref_level = 1'b0;
  logic [7:0] codes [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A};

  global_config_registers i_global_config_registers (.sys_clk_i, .nrst_i, .ce_i, .io_addr_i, .io_wr_i, .io_rd_i,
    .io_wdata_i, .io_rdata_o, .io_rdata_valid_o, .unit_select_o, .unit_index_o, .unit_wdata_o, .unit_wr_o,
    .unit_rd_o, .unit_rdata_i, .main_supply_reset_o, .reference_clock_input_i, .input_clock_rate_select_o,
    .ref_tick_o, .transmit_holding_register_write_i, .bit_tick_i, .tx_start_o, .serial_irq_req_i, .serial_irq1_o,
    .serial_irq2_o, .shared_irq_o, .shared_irq_oe_o, .serial_out_strap_pin_i, .bit_select_strap_pin_i,
    .sequencing_strap_pin_i, .alternate_config_port_o, .bit_select_function_status_o,
    .general_io_group_six_enable_o, .sequencing_status_o);

  always #5 sys_clk_i = !sys_clk_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // reference pin wanders randomly so the divider logic sees real edges
  always @(negedge sys_clk_i)
  begin
    rs = xs(rs);
    reference_clock_input_i <= ref_hold ? ref_level : rs[3];
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one strobe then an idle cycle, so strobes never re-rise in the same step
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = wr;
    io_rd_i = !wr;
    @(negedge sys_clk_i);
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    @(negedge sys_clk_i);
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    io(1'b1, base, idx);
    io(1'b1, base + 16'h0001, d);
  endtask

  task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
    io(1'b1, base, idx);
    rq.push_back(exp);
    io(1'b0, base + 16'h0001, 8'h00);
  endtask

  always @(negedge sys_clk_i)
  begin
    if (io_rdata_valid_o === 1'b1)
      check(io_rdata_o, (rq.size() > 0) ? rq.pop_front() : 16'hFFFF, "read data");
    if (unit_wr_o === 1'b1)
      check(unit_wdata_o, (wq.size() > 0) ? wq.pop_front() : 16'hFFFF, "unit write data");
    if (ref_tick_o === 1'b1)
      ticks++;
  end

  initial
  begin
    bit_select_strap_pin_i = seed[0];
    sequencing_strap_pin_i = seed[1];
    repeat (3) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    check(alternate_config_port_o, 16'h0, "port pair");
    check(bit_select_function_status_o, bit_select_strap_pin_i, "bit select status");
    check(general_io_group_six_enable_o, !bit_select_strap_pin_i, "group six");
    check(sequencing_status_o, sequencing_strap_pin_i, "sequencing");
    rreg(IDX_UNIT_NUMBER, UNIT_NUMBER_RESET);
    check(unit_select_o, 16'h0001, "unit select reset");
    rreg(IDX_SERIAL_SHARE, 8'h00);
    foreach (codes[i])
    begin
      wreg(IDX_UNIT_NUMBER, codes[i]);
      check(unit_select_o, (codes[i] == 8'h08) ? 16'h0 : 16'h0001 << codes[i], "unit select");
      rreg(IDX_UNIT_NUMBER, codes[i]);
    end
    // a write while the enable is low must leave the last unit selected
    ce_i = 1'b0;
    wreg(IDX_UNIT_NUMBER, 8'h05);
    ce_i = 1'b1;
    check(unit_select_o, 16'h0400, "frozen unit select");
    for (logic [7:0] idx = IDX_RSVD_FIRST; idx <= IDX_RSVD_LAST; idx++)
    begin
      wreg(idx, 8'hFF);
      rreg(idx, 8'h00);
    end
    seed = xs(seed);
    v = seed[7:0];
    wreg(IDX_SERIAL_SHARE, v);
    rreg(IDX_SERIAL_SHARE, v & 8'h87);
    check(input_clock_rate_select_o, v[CLK_RATE_BIT], "clock rate");
    wreg(IDX_PORT_SELECT, {6'h3B, !bit_select_strap_pin_i, !sequencing_strap_pin_i});
    rreg(IDX_PORT_SELECT, {6'h00, bit_select_strap_pin_i, sequencing_strap_pin_i});
    wreg(IDX_PORT_SELECT, 8'h10);
    base = CFG_PORT_ALT;
    check(alternate_config_port_o, 16'h1, "port pair");
    io(1'b0, CFG_PORT_STD + 16'h0001, 8'h00);
    seed = xs(seed);
    wq.push_back(seed[15:8]);
    wreg(IDX_UNIT_FIRST, seed[15:8]);
    check(unit_index_o, IDX_UNIT_FIRST, "unit index");
    unit_rdata_i = seed[23:16];
    rreg(IDX_UNIT_FIRST, seed[23:16]);
    wreg(IDX_SERIAL_SHARE, 8'h00);
    transmit_holding_register_write_i = 2'h1;
    @(negedge sys_clk_i);
    transmit_holding_register_write_i = 2'h0;
    check(tx_start_o, 16'h1, "immediate start");
    wreg(IDX_SERIAL_SHARE, 8'h04);
    transmit_holding_register_write_i = 2'h2;
    @(negedge sys_clk_i);
    transmit_holding_register_write_i = 2'h0;
    check(tx_start_o, 16'h0, "delayed start early");
    bit_tick_i = 2'h2;
    @(negedge sys_clk_i);
    bit_tick_i = 2'h0;
    check(tx_start_o, 16'h2, "delayed start");
    wreg(IDX_SERIAL_SHARE, 8'h00);
    serial_irq_req_i = 2'h1;
    @(negedge sys_clk_i);
    check({serial_irq1_o, shared_irq_oe_o}, 16'h2, "separate irq");
    serial_irq_req_i = 2'h0;
    wreg(IDX_SERIAL_SHARE, 8'h01);
    serial_irq_req_i = 2'h2;
    @(negedge sys_clk_i);
    check({serial_irq2_o, shared_irq_oe_o, shared_irq_o}, 16'h2, "shared level");
    serial_irq_req_i = 2'h0;
    @(negedge sys_clk_i);
    check(shared_irq_oe_o, 16'h0, "shared release");
    wreg(IDX_SERIAL_SHARE, 8'h03);
    serial_irq_req_i = 2'h1;
    n = 0;
    repeat (12)
    begin
      @(negedge sys_clk_i);
      n += (shared_irq_oe_o === 1'b1);
    end
    serial_irq_req_i = 2'h0;
    check(16'(n), 16'(IRQ_PULSE_CYCLES), "pulse width");
    // pin held by the bench so edge counts are exact; 48MHz mode ticks on every second rising edge
    ref_hold = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wreg(IDX_SERIAL_SHARE, k ? 8'h80 : 8'h00);
      t0 = ticks;
      repeat (8)
      begin
        ref_level = !ref_level;
        repeat (3) @(negedge sys_clk_i);
      end
      check(16'(ticks - t0), k ? 16'h0004 : 16'h0002, "reference ticks");
    end
    io(1'b1, base, IDX_SOFT_RESET);
    io_addr_i = base + 16'h0001;
    io_wdata_i = 8'h01;
    io_wr_i = 1'b1;
    @(negedge sys_clk_i);
    io_wr_i = 1'b0;
    check(main_supply_reset_o, 16'h1, "soft reset pulse");
    @(negedge sys_clk_i);
    rreg(IDX_UNIT_NUMBER, UNIT_NUMBER_RESET);
    rreg(IDX_SERIAL_SHARE, 8'h00);
    rreg(IDX_SOFT_RESET, 8'h00);
    check(alternate_config_port_o, 16'h1, "port pair kept");
    // bounded drain of outstanding reads
    for (int i = 0; i < 20 && rq.size() > 0; i++)
      @(negedge sys_clk_i);
    if (rq.size() > 0 || wq.size() > 0)
      bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
